// ---- common/flux_sensor_map.svh ----
// What this block does
// - Serial output driven only while select is low, released while select is high
// - Clock and data input are ignored while select is high
// - Data input is sampled on every rising serial clock edge while select is low
// - Serial output bit changes on each of the first 12 falling serial clock edges of a frame, then stays low
// - Read returns the 12-bit result; master holds data input low meanwhile
// - First sample tracks while idle with select high; held from select fall until converted and select is high
// - Second sample tracks from 32 us, held at 96 us, then converted
// - Finished result enters the output shift register at next select fall
// - Master paces sampling with select falls; acquisition ignores the serial clock
// - Zero field reads 2048; north pole raises the count
// - Reset clears every flip-flop and register to zero
// - Filtered output is W times sample plus 1-W times previous output
// - Filter keeps interface timing; one output per sample, no decimation
// - Previous value starts at zero and survives filter setting changes
// - Trim and filter written serially, storable, reloaded after every power-up
// - Write command carries 3-bit filter, 6-bit trim and program enable
// - Filter code 0 is off; codes 1..7 weight 1/2 down to 1/128
// - Trim 0 is lowest sensitivity, all ones highest, about 0.8 percent steps
// - Program enable burns fields at the next command's select fall; ones permanent
`ifndef FLUX_SENSOR_MAP_SVH
`define FLUX_SENSOR_MAP_SVH

`define FLX_RES_W          12
`define FLX_FRAME_W        16
`define FLX_MIDSCALE       15'sh0800
`define FLX_FULLSCALE      15'sh0fff
`define FLX_ZERO_CODE      15'sh0000
`define FLX_WR_PREFIX      2'h2
`define FLX_RX_LAST        5'h0f
`define FLX_TX_LAST        4'hb
`define FLX_TX_DONE        4'hc
`define FLX_GAIN_UNITY     10'h100
`define FLX_GAIN_TRIM_OFS  10'h040
`define FLX_GAIN_SHIFT     8
`define FLX_CLK_NS         25
`define FLX_T_TRACK2_NS    32000
`define FLX_T_HOLD2_NS     96000
`define FLX_TMR_W          12
`define FLX_TRACK2_CYC     ((`FLX_T_TRACK2_NS + `FLX_CLK_NS - 1) / `FLX_CLK_NS)
`define FLX_HOLD2_CYC      (`FLX_T_HOLD2_NS / `FLX_CLK_NS)

`endif

// ---- common/flux_sensor_pkg.sv ----
`include "flux_sensor_map.svh"

package flux_sensor_pkg;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_HOLD1,
        ACQ_TRACK2,
        ACQ_CONV
    } acq_state_t;

    typedef struct packed {
        logic [2:0] filt;
        logic [5:0] trim;
    } settings_t;

    typedef struct packed {
        logic [1:0] prefix;
        logic [2:0] filt;
        logic [5:0] trim;
        logic [3:0] pad;
        logic       program_enable;
    } write_frame_t;

    typedef struct packed {
        logic [4:0]               rxCnt;
        logic [`FLX_FRAME_W-1:0]  rxShift;
    } rx_shift_t;

    typedef struct packed {
        logic [`FLX_FRAME_W-1:0]  rxWord;
        logic                     rxToggle;
    } rx_capture_t;

    typedef struct packed {
        logic [3:0] txCnt;
        logic       serialOut;
        logic       serialOutEn;
    } tx_state_t;

    typedef struct packed {
        logic                    csMeta;
        logic                    csSync;
        logic                    csPrev;
        logic                    togMeta;
        logic                    togSync;
        logic                    togPrev;
        acq_state_t              acq;
        logic [`FLX_TMR_W-1:0]   tmr;
        logic                    holdFirst;
        logic                    trackSecond;
        logic                    convStrobe;
        settings_t               active;
        logic                    fuseLoaded;
        logic [`FLX_RES_W-1:0]   result;
        logic [`FLX_RES_W-1:0]   outWord;
        logic                    resultValid;
        logic                    burnPend;
        settings_t               burnData;
        logic                    burnStrobe;
    } readout_state_t;

endpackage : flux_sensor_pkg

// ---- hw/serial_link.sv ----
`timescale 1ns/1ps
`include "flux_sensor_map.svh"

module serial_link (
    input  wire logic                    sclk,
    input  wire logic                    rst,
    input  wire logic                    csN,
    input  wire logic                    serial_in,
    input  wire logic [`FLX_RES_W-1:0]   txWord,
    output logic                         serial_out,
    output logic                         serialOutEn,
    output logic [`FLX_FRAME_W-1:0]      rxWord,
    output logic                         rxToggle
);

    flux_sensor_pkg::rx_shift_t   sh_q;
    flux_sensor_pkg::rx_shift_t   sh_d;
    flux_sensor_pkg::rx_capture_t cap_q;
    flux_sensor_pkg::rx_capture_t cap_d;
    flux_sensor_pkg::tx_state_t   tx_q;
    flux_sensor_pkg::tx_state_t   tx_d;

    // Receive side, MSB first on rising edges
    always_comb begin
        sh_d  = sh_q;
        cap_d = cap_q;
        sh_d.rxShift = {sh_q.rxShift[`FLX_FRAME_W-2:0], serial_in};
        if (sh_q.rxCnt != `FLX_RX_LAST + 5'h01) begin
            sh_d.rxCnt = sh_q.rxCnt + 5'h01;
        end
        if (!csN && sh_q.rxCnt == `FLX_RX_LAST) begin
            cap_d.rxWord   = sh_d.rxShift;
            cap_d.rxToggle = ~cap_q.rxToggle;
        end
    end

    // Select high holds the frame counters clear
    always_ff @(posedge sclk or posedge rst or posedge csN) begin
        if (rst || csN) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            cap_q <= '0;
        end else begin
            cap_q <= cap_d;
        end
    end

    // Transmit side, next bit launched on falling edges
    always_comb begin
        tx_d = tx_q;
        tx_d.serialOutEn = 1'b1;
        if (tx_q.txCnt == `FLX_TX_DONE) begin
            tx_d.serialOut = 1'b0;
        end else begin
            tx_d.serialOut = txWord[`FLX_TX_LAST - tx_q.txCnt];
            tx_d.txCnt     = tx_q.txCnt + 4'h1;
        end
    end

    always_ff @(negedge sclk or posedge rst or posedge csN) begin
        if (rst || csN) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign serial_out  = tx_q.serialOut;
    assign serialOutEn = tx_q.serialOutEn;
    assign rxWord      = cap_q.rxWord;
    assign rxToggle    = cap_q.rxToggle;

endmodule : serial_link

// ---- hw/flux_sensor_serial_readout.sv ----
`timescale 1ns/1ps
`include "flux_sensor_map.svh"

module flux_sensor_serial_readout #(
    parameter int RES_W = `FLX_RES_W
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         sclk,
    input  wire logic                         csN,
    input  wire logic                         serial_in,
    output logic                              serial_out,
    output logic                              serialOutEn,
    input  wire logic signed [RES_W-1:0]      hallDiff,
    output logic                              holdFirst,
    output logic                              trackSecond,
    output logic                              convStrobe,
    input  wire flux_sensor_pkg::settings_t   fuseBits,
    output logic                              burnStrobe,
    output flux_sensor_pkg::settings_t        burnBits,
    output flux_sensor_pkg::settings_t        activeSettings,
    output logic [RES_W-1:0]                  resultCode,
    output logic                              resultValid
);

    localparam logic [`FLX_TMR_W-1:0] TRACK2_CYC = `FLX_TMR_W'(`FLX_TRACK2_CYC);
    localparam logic [`FLX_TMR_W-1:0] HOLD2_CYC  = `FLX_TMR_W'(`FLX_HOLD2_CYC);

    flux_sensor_pkg::readout_state_t s_q;
    flux_sensor_pkg::readout_state_t s_d;

    logic [`FLX_FRAME_W-1:0]       rxWord;
    logic                          rxToggle;
    flux_sensor_pkg::write_frame_t cmd;

    serial_link u_link (
        .sclk        (sclk),
        .rst         (rst),
        .csN         (csN),
        .serial_in   (serial_in),
        .txWord      (s_q.outWord),
        .serial_out  (serial_out),
        .serialOutEn (serialOutEn),
        .rxWord      (rxWord),
        .rxToggle    (rxToggle)
    );

    assign cmd = rxWord;

    always_comb begin
        logic                   csFall;
        logic                   cmdArrived;
        logic [9:0]             gain;
        logic signed [22:0]     diffWide;
        logic signed [22:0]     gainWide;
        logic signed [22:0]     prod;
        logic signed [14:0]     code;
        logic [RES_W-1:0]       raw;
        logic signed [12:0]     delta;
        logic signed [12:0]     filtered;

        s_d        = s_q;
        csFall     = 1'b0;
        cmdArrived = 1'b0;
        gain       = '0;
        diffWide   = '0;
        gainWide   = '0;
        prod       = '0;
        code       = '0;
        raw        = '0;
        delta      = '0;
        filtered   = '0;

        // Select and link toggle cross into this clock
        s_d.csMeta  = csN;
        s_d.csSync  = s_q.csMeta;
        s_d.csPrev  = s_q.csSync;
        s_d.togMeta = rxToggle;
        s_d.togSync = s_q.togMeta;
        s_d.togPrev = s_q.togSync;
        csFall      = s_q.csPrev && !s_q.csSync;
        cmdArrived  = s_q.togPrev != s_q.togSync;

        s_d.convStrobe = 1'b0;
        s_d.burnStrobe = 1'b0;

        // Stored settings come back once after every reset
        if (!s_q.fuseLoaded) begin
            s_d.active     = fuseBits;
            s_d.fuseLoaded = 1'b1;
        end

        // Acquisition sequence, paced only by select
        case (s_q.acq)
            flux_sensor_pkg::ACQ_IDLE: begin
                if (s_q.csSync) begin
                    s_d.holdFirst = 1'b0;
                end
            end
            flux_sensor_pkg::ACQ_HOLD1: begin
                s_d.tmr = s_q.tmr + `FLX_TMR_W'(1);
                if (s_d.tmr == TRACK2_CYC) begin
                    s_d.trackSecond = 1'b1;
                    s_d.acq         = flux_sensor_pkg::ACQ_TRACK2;
                end
            end
            flux_sensor_pkg::ACQ_TRACK2: begin
                s_d.tmr = s_q.tmr + `FLX_TMR_W'(1);
                if (s_d.tmr == HOLD2_CYC) begin
                    s_d.trackSecond = 1'b0;
                    s_d.convStrobe  = 1'b1;
                    s_d.acq         = flux_sensor_pkg::ACQ_CONV;
                end
            end
            flux_sensor_pkg::ACQ_CONV: begin
                // Trim scales the offset-free difference around midscale
                gain     = `FLX_GAIN_UNITY + {3'h0, s_q.active.trim, 1'b0}
                           - `FLX_GAIN_TRIM_OFS;
                diffWide = 23'(hallDiff);
                gainWide = 23'($signed({1'b0, gain}));
                prod     = diffWide * gainWide;
                code     = 15'(prod >>> `FLX_GAIN_SHIFT) + `FLX_MIDSCALE;
                if (code < `FLX_ZERO_CODE) begin
                    code = `FLX_ZERO_CODE;
                end else if (code > `FLX_FULLSCALE) begin
                    code = `FLX_FULLSCALE;
                end
                raw = code[RES_W-1:0];

                // Weight 2^-k, truncating, previous value kept
                delta    = $signed({1'b0, raw}) - $signed({1'b0, s_q.result});
                filtered = $signed({1'b0, s_q.result})
                           + (delta >>> s_q.active.filt);
                s_d.result      = filtered[RES_W-1:0];
                s_d.resultValid = 1'b1;
                s_d.holdFirst   = !s_q.csSync;
                s_d.acq         = flux_sensor_pkg::ACQ_IDLE;
            end
            default: begin
                s_d.acq = flux_sensor_pkg::ACQ_IDLE;
            end
        endcase

        // Each select fall restarts acquisition and loads the last result
        if (csFall) begin
            s_d.holdFirst   = 1'b1;
            s_d.trackSecond = 1'b0;
            s_d.tmr         = '0;
            s_d.acq         = flux_sensor_pkg::ACQ_HOLD1;
            s_d.outWord     = s_q.result;
            if (s_q.burnPend) begin
                s_d.burnStrobe = 1'b1;
                s_d.burnPend   = 1'b0;
            end
        end

        // Write frames carry settings; program requests wait one command
        if (cmdArrived && cmd.prefix == `FLX_WR_PREFIX) begin
            s_d.active.filt = cmd.filt | fuseBits.filt;
            s_d.active.trim = cmd.trim | fuseBits.trim;
            if (cmd.program_enable) begin
                s_d.burnPend      = 1'b1;
                s_d.burnData.filt = cmd.filt;
                s_d.burnData.trim = cmd.trim;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign holdFirst      = s_q.holdFirst;
    assign trackSecond    = s_q.trackSecond;
    assign convStrobe     = s_q.convStrobe;
    assign burnStrobe     = s_q.burnStrobe;
    assign burnBits       = s_q.burnData;
    assign activeSettings = s_q.active;
    assign resultCode     = s_q.result;
    assign resultValid    = s_q.resultValid;

endmodule : flux_sensor_serial_readout

// ---- verification/flux_sensor_serial_readout_checker.sv ----
`timescale 1ns/1ps

module flux_sensor_serial_readout_checker #(
    parameter int RES_W = 12
) (
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire logic                       csN,
    input wire logic                       serialOutEn,
    input wire logic                       holdFirst,
    input wire logic                       trackSecond,
    input wire logic                       convStrobe,
    input wire flux_sensor_pkg::settings_t fuseBits,
    input wire logic                       burnStrobe,
    input wire flux_sensor_pkg::settings_t activeSettings,
    input wire logic                       resultValid
);
    localparam int TRACK2 = 1280;
    localparam int HOLD2  = 3840;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [15:0] sinceHold_q;
    // Cycles since the first sample was held
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sinceHold_q <= 16'h0;
        end else if ($rose(holdFirst)) begin
            sinceHold_q <= 16'h1;
        end else if (sinceHold_q != 16'hffff) begin
            sinceHold_q <= sinceHold_q + 16'h1;
        end
    end
    property p_out_release; csN |-> !serialOutEn; endproperty
    a_out_release: assert property (p_out_release) else $error("output driven while idle");
    property p_hold_first; $fell(csN) |-> ##[2:6] holdFirst; endproperty
    a_hold_first: assert property (p_hold_first) else $error("first sample not held");
    property p_track_second; $rose(trackSecond) |-> sinceHold_q == TRACK2; endproperty
    a_track_second: assert property (p_track_second) else $error("second track mistimed");
    property p_conv_time; convStrobe |-> sinceHold_q == HOLD2 && $fell(trackSecond); endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion mistimed");
    property p_single_conv; convStrobe |=> !convStrobe [*8]; endproperty
    a_single_conv: assert property (p_single_conv) else $error("extra conversion");
    property p_valid_after; convStrobe |-> ##2 resultValid; endproperty
    a_valid_after: assert property (p_valid_after) else $error("result not produced");
    property p_valid_keep; resultValid |=> resultValid; endproperty
    a_valid_keep: assert property (p_valid_keep) else $error("result valid dropped");
    property p_reset_clear;
        disable iff (1'b0) rst |=> !serialOutEn && !holdFirst && !convStrobe && !burnStrobe
            && !resultValid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");
    property p_fuse_load; $fell(rst) |=> activeSettings == fuseBits; endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("stored settings not loaded");
    property p_burn_pulse; burnStrobe |-> !csN ##1 !burnStrobe; endproperty
    a_burn_pulse: assert property (p_burn_pulse) else $error("bad burn pulse");
    c_conv: cover property (convStrobe);
    c_burn: cover property (burnStrobe);
    c_track: cover property ($rose(trackSecond));
endmodule : flux_sensor_serial_readout_checker

bind flux_sensor_serial_readout flux_sensor_serial_readout_checker #(
    .RES_W(RES_W)
) chk_u (
    .ref_clk(ref_clk), .rst(rst), .csN(csN), .serialOutEn(serialOutEn),
    .holdFirst(holdFirst), .trackSecond(trackSecond), .convStrobe(convStrobe),
    .fuseBits(fuseBits), .burnStrobe(burnStrobe), .activeSettings(activeSettings),
    .resultValid(resultValid)
);

// ---- verification/serial_master_model.sv ----
`timescale 1ns/1ps

module serial_master_model (
    output logic     csN,
    output logic     sclk,
    output logic     serial_in,
    input wire logic sdoLine
);
    initial begin
        csN       = 1'b1;
        sclk      = 1'b1;
        serial_in = 1'b0;
    end
    // Data line keeps moving outside frames
    always #10 if (csN) serial_in = ~serial_in;
    task automatic frame(input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0;
        #3 csN = 1'b0;
        serial_in = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            sclk      = 1'b0;
            serial_in = w[n-1-i];
            #7.5 sclk = 1'b1;
            r = {r[14:0], sdoLine};
            #7.5;
        end
        #50 csN = 1'b1;
    endtask : frame
    // Clock pulses while deselected
    task automatic junk();
        for (int i = 0; i < 16; i++) begin
            #7.5 sclk = 1'b0;
            #7.5 sclk = 1'b1;
        end
    endtask : junk
endmodule : serial_master_model

// ---- verification/flux_sensor_serial_readout_tb.sv ----
`timescale 1ns/1ps

module flux_sensor_serial_readout_tb;
    logic                       ref_clk  = 1'b0;
    logic                       rst      = 1'b0;
    logic signed [11:0]         hallDiff = 12'sh100;
    flux_sensor_pkg::settings_t fuseBits = 9'h020;
    flux_sensor_pkg::settings_t burnBits, activeSettings, burnSeen;
    wire                        csN, sclk, serial_in;
    logic                       serial_out, serialOutEn, holdFirst, trackSecond, convStrobe;
    logic                       burnStrobe, resultValid;
    logic [11:0]                resultCode;
    int                         nFail = 0, totalChecks = 0, burnCount = 0;
    // Released line shows the opposite level
    wire sdoLine = serialOutEn ? serial_out : ~serial_out;
    always #12.5 ref_clk = ~ref_clk;
    // Storage model: burnt ones stay set
    always @(posedge ref_clk) if (burnStrobe) begin
        fuseBits  <= fuseBits | burnBits;
        burnSeen  <= burnBits;
        burnCount <= burnCount + 1;
    end
    serial_master_model master_u (
        .csN(csN), .sclk(sclk), .serial_in(serial_in), .sdoLine(sdoLine)
    );
    flux_sensor_serial_readout dut_u (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csN(csN), .serial_in(serial_in),
        .serial_out(serial_out), .serialOutEn(serialOutEn), .hallDiff(hallDiff),
        .holdFirst(holdFirst), .trackSecond(trackSecond), .convStrobe(convStrobe),
        .fuseBits(fuseBits), .burnStrobe(burnStrobe), .burnBits(burnBits),
        .activeSettings(activeSettings), .resultCode(resultCode), .resultValid(resultValid)
    );
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic gap();
        repeat (20000) @(posedge ref_clk);
    endtask : gap
    task automatic closeOut();
        $display("checks %0d failures %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : closeOut
    task automatic test_first_read();
        logic [15:0] r;
        master_u.frame(12, 16'h0000, r);
        check(r, 16'h0000);
        $display("test first_read done");
    endtask : test_first_read
    task automatic test_program();
        logic [15:0] r;
        master_u.frame(16, 16'h8c01, r);
        check({4'h0, r[15:4]}, 16'h0900);
        repeat (8) @(posedge ref_clk);
        check({7'h0, activeSettings}, 16'h0060);
        check(16'(burnCount), 16'h0000);
        $display("test program done");
    endtask : test_program
    task automatic test_zero_write();
        logic [15:0] r;
        hallDiff <= 12'sh300;
        master_u.frame(16, 16'h8000, r);
        check({4'h0, r[15:4]}, 16'h0900);
        repeat (8) @(posedge ref_clk);
        check(16'(burnCount), 16'h0001);
        check({7'h0, burnSeen}, 16'h0060);
        check({7'h0, activeSettings}, 16'h0060);
        $display("test zero_write done");
    endtask : test_zero_write
    task automatic test_idle_ignore();
        master_u.junk();
        repeat (8) @(posedge ref_clk);
        check({7'h0, activeSettings}, 16'h0060);
        check({15'h0, serialOutEn}, 16'h0000);
        $display("test idle_ignore done");
    endtask : test_idle_ignore
    task automatic test_filter_read();
        logic [15:0] r;
        master_u.frame(12, 16'h0000, r);
        check(r, 16'h0a00);
        check({4'h0, resultCode}, 16'h0a00);
        $display("test filter_read done");
    endtask : test_filter_read
    // Preview write over burnt bits: filter 3, trim all ones
    task automatic test_preview();
        logic [15:0] r;
        master_u.frame(16, 16'h93e0, r);
        check({4'h0, r[15:4]}, 16'h0a80);
        repeat (8) @(posedge ref_clk);
        check({7'h0, activeSettings}, 16'h00ff);
        repeat (4000) @(posedge ref_clk);
        check({4'h0, resultCode}, 16'h0aa7);
        $display("test preview done");
    endtask : test_preview
    initial begin
        repeat (90000) @(posedge ref_clk);
        nFail++;
        closeOut();
    end
    initial begin
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        test_first_read();
        gap();
        test_program();
        gap();
        test_zero_write();
        test_idle_ignore();
        gap();
        test_filter_read();
        gap();
        test_preview();
        closeOut();
    end
endmodule : flux_sensor_serial_readout_tb
